// ==== rtl/flag_pkg.sv ====
// Shared constants and types for the sensor status flag logic
package flag_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PRIMARY   = 8'h0B;
    localparam logic [7:0] IDX_SECONDARY = 8'h45;
    localparam logic [7:0] IDX_KNOCK_THR = 8'h20;
    localparam logic [7:0] IDX_KNOCK_DUR = 8'h21;
    localparam logic [7:0] IDX_KNOCK_GAP = 8'h22;
    localparam logic [7:0] IDX_KNOCK_SPN = 8'h23;
    localparam logic [7:0] IDX_FIFO_POL  = 8'h28;
    localparam logic [7:0] IDX_FIFO_LVL  = 8'h29;
    localparam logic [7:0] IDX_CONV_CTL  = 8'h2C;
    localparam logic [7:0] IDX_INT_STAT  = 8'h50;
    localparam logic [7:0] IDX_INT_MASK  = 8'h51;
    localparam logic [7:0] IDX_DATA_A_LO = 8'h08;
    localparam logic [7:0] IDX_DATA_A_HI = 8'h0A;
    localparam logic [7:0] IDX_DATA_B_LO = 8'h0E;
    localparam logic [7:0] IDX_DATA_B_HI = 8'h17;
    // ------------------------------------------------------------
    // Field layouts, sizes and reset values
    // ------------------------------------------------------------
    localparam int          FIFO_DEPTH     = 512;
    localparam logic [9:0]  FIFO_FULL      = 10'h200;
    localparam logic [1:0]  POL_OFF        = 2'h0;
    localparam logic [1:0]  POL_OLDEST     = 2'h1;
    localparam logic [1:0]  POL_STREAM     = 2'h2;
    localparam logic [7:0]  SECONDARY_RST  = 8'h00;
    localparam logic [7:0]  INT_MASK_RST   = 8'h00;
    localparam logic [13:0] KNOCK_THR_RST  = 14'h0400;
    localparam logic [7:0]  KNOCK_DUR_RST  = 8'h04;
    localparam logic [7:0]  KNOCK_GAP_RST  = 8'h04;
    localparam logic [7:0]  KNOCK_SPN_RST  = 8'h10;
    localparam logic [9:0]  FIFO_LVL_RST   = 10'h080;
    // Interrupt status bit positions
    localparam int INT_NEW_SAMPLE = 0;
    localparam int INT_LEVEL      = 1;
    localparam int INT_OVERFLOW   = 2;
    localparam int INT_RELOAD     = 3;
    localparam int INT_KEEPALIVE  = 4;
    localparam int INT_OVER       = 5;
    localparam int INT_UNDER      = 6;
    localparam int INT_KNOCK      = 7;

    // Primary flag register, bits 3..0
    typedef struct packed {
        logic overflow;
        logic queue_level_flag;
        logic nonempty;
        logic new_sample;
    } primary_flags_s;

    // Secondary event flag register layout, bit 7 down to bit 0
    typedef struct packed {
        logic fuse_error;
        logic mem_reload;
        logic reserved;
        logic keepalive;
        logic conversion_over_limit_flag;
        logic conversion_under_limit_flag;
        logic double_knock;
        logic single_knock;
    } secondary_flags_s;

    typedef enum logic [4:0] {
        KN_IDLE   = 5'b00001,
        KN_ABOVE1 = 5'b00010,
        KN_GAP    = 5'b00100,
        KN_WAIT2  = 5'b01000,
        KN_ABOVE2 = 5'b10000
    } knock_state_e;
endpackage : flag_pkg

// ==== rtl/sensor_status_flag_logic.sv ====
// Status flag logic of a motion sensor, reached over APB
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
// Summary of operation
// R1: Overflow sets flag, storing stops until pop
// R2: Overflow flag only in keep-oldest policy
// R3: Level flag on push exceeding threshold
// R4: Nonempty flag high while samples wait
// R5: New-sample set by sample, cleared by data read
// R6: New-sample never set during data register read
// R7: Clear flag, sample during read: set after read
// R8: Set flag cleared at read start, held clear
// R9: Fuse error reported in secondary register
// R10: Memory reload sticky, cleared by secondary read
// R11: Keep-alive expiry sticky; read clears, restarts timer
// R12: Over-limit from temp or external, temp-only option
// R13: Under-limit from temp or external, temp-only option
// R14: Single knock: short excursion above threshold
// R15: Double knock: second after gap, within span
// R16: Secondary register at 0x45, resets to zero
// R17: Event coinciding with clearing read wins
module sensor_status_flag_logic (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_valid,
    input  wire logic [13:0] sample_magnitude,
    input  wire logic        fifo_pop,
    output logic             fifo_store,
    input  wire logic        fuse_uncorrectable,
    input  wire logic        mem_reload_event,
    input  wire logic        keepalive_expired,
    output logic             keepalive_restart,
    input  wire logic        temp_over,
    input  wire logic        temp_under,
    input  wire logic        ext_over,
    input  wire logic        ext_under,
    output logic             irq
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Data range reads steer the new-sample flag
    function automatic logic is_data_idx(input logic [7:0] idx);
        return (idx >= flag_pkg::IDX_DATA_A_LO && idx <= flag_pkg::IDX_DATA_A_HI) ||
               (idx >= flag_pkg::IDX_DATA_B_LO && idx <= flag_pkg::IDX_DATA_B_HI);
    endfunction : is_data_idx

    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            flag_pkg::IDX_PRIMARY, flag_pkg::IDX_SECONDARY, flag_pkg::IDX_KNOCK_THR,
            flag_pkg::IDX_KNOCK_DUR, flag_pkg::IDX_KNOCK_GAP, flag_pkg::IDX_KNOCK_SPN,
            flag_pkg::IDX_FIFO_POL, flag_pkg::IDX_FIFO_LVL, flag_pkg::IDX_CONV_CTL,
            flag_pkg::IDX_INT_STAT, flag_pkg::IDX_INT_MASK: return 1'b1;
            default: return is_data_idx(idx);
        endcase
    endfunction : is_mapped

    logic [7:0]                  idx;
    logic                        acc_done;
    logic                        wr_en;
    logic                        rd_done;
    logic                        data_read_active;
    logic [13:0]                 knock_thr_q;
    logic [7:0]                  knock_dur_q;
    logic [7:0]                  knock_gap_q;
    logic [7:0]                  knock_spn_q;
    logic [1:0]                  fifo_pol_q;
    logic [9:0]                  fifo_lvl_q;
    logic                        temp_only_q;
    logic [7:0]                  int_stat_q;
    logic [7:0]                  int_mask_q;
    logic [31:0]                 prdata_q;
    logic [9:0]                  count_q;
    logic                        store_ok_q;
    logic                        pend_q;
    flag_pkg::primary_flags_s    prim_q;
    flag_pkg::secondary_flags_s  sec_q;
    flag_pkg::knock_state_e      kn_q;
    logic [7:0]                  kn_cnt_q;
    logic                        above;
    logic                        push;
    logic                        single_ev;
    logic                        double_ev;
    logic                        over_ev;
    logic                        under_ev;
    logic                        sec_read;
    logic [7:0]                  int_ev;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error
    assign idx              = paddr[9:2];
    assign pready           = 1'b1;
    assign pslverr          = psel && penable && (!is_mapped(idx) || paddr[11:10] != 2'h0);
    assign acc_done         = psel && penable && !pslverr;
    assign wr_en            = acc_done && pwrite;
    assign rd_done          = acc_done && !pwrite;
    assign data_read_active = psel && !pwrite && is_data_idx(idx);
    assign sec_read         = rd_done && idx == flag_pkg::IDX_SECONDARY;
    assign prdata           = prdata_q;

    // Control registers written by software
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            knock_thr_q <= flag_pkg::KNOCK_THR_RST;
            knock_dur_q <= flag_pkg::KNOCK_DUR_RST;
            knock_gap_q <= flag_pkg::KNOCK_GAP_RST;
            knock_spn_q <= flag_pkg::KNOCK_SPN_RST;
            fifo_pol_q  <= flag_pkg::POL_OFF;
            fifo_lvl_q  <= flag_pkg::FIFO_LVL_RST;
            temp_only_q <= 1'b0;
            int_mask_q  <= flag_pkg::INT_MASK_RST;
        end else if (wr_en) begin
            case (idx)
                flag_pkg::IDX_KNOCK_THR: knock_thr_q <= pwdata[13:0];
                flag_pkg::IDX_KNOCK_DUR: knock_dur_q <= pwdata[7:0];
                flag_pkg::IDX_KNOCK_GAP: knock_gap_q <= pwdata[7:0];
                flag_pkg::IDX_KNOCK_SPN: knock_spn_q <= pwdata[7:0];
                flag_pkg::IDX_FIFO_POL:  fifo_pol_q  <= pwdata[1:0];
                flag_pkg::IDX_FIFO_LVL:  fifo_lvl_q  <= pwdata[9:0];
                flag_pkg::IDX_CONV_CTL:  temp_only_q <= pwdata[0];
                flag_pkg::IDX_INT_MASK:  int_mask_q  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data captured in the setup phase so it stands through access
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (idx)
                flag_pkg::IDX_PRIMARY:   prdata_q <= {28'h0, prim_q};
                flag_pkg::IDX_SECONDARY: prdata_q <= {24'h0, sec_q};
                flag_pkg::IDX_KNOCK_THR: prdata_q <= {18'h0, knock_thr_q};
                flag_pkg::IDX_KNOCK_DUR: prdata_q <= {24'h0, knock_dur_q};
                flag_pkg::IDX_KNOCK_GAP: prdata_q <= {24'h0, knock_gap_q};
                flag_pkg::IDX_KNOCK_SPN: prdata_q <= {24'h0, knock_spn_q};
                flag_pkg::IDX_FIFO_POL:  prdata_q <= {30'h0, fifo_pol_q};
                flag_pkg::IDX_FIFO_LVL:  prdata_q <= {22'h0, fifo_lvl_q};
                flag_pkg::IDX_CONV_CTL:  prdata_q <= {31'h0, temp_only_q};
                flag_pkg::IDX_INT_STAT:  prdata_q <= {24'h0, int_stat_q};
                flag_pkg::IDX_INT_MASK:  prdata_q <= {24'h0, int_mask_q};
                default:                 prdata_q <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sample queue occupancy and primary flags
    // ------------------------------------------------------------
    // Storage lives outside; only occupancy is tracked here
    assign push       = sample_valid && fifo_pol_q != flag_pkg::POL_OFF && store_ok_q &&
                        (count_q != flag_pkg::FIFO_FULL || fifo_pol_q == flag_pkg::POL_STREAM);
    assign fifo_store = push;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= 10'h0;
        end else if (fifo_pol_q == flag_pkg::POL_OFF) begin
            count_q <= 10'h0;
        // Push with pop leaves occupancy unchanged, except at empty, where it rises by one, and at full in stream policy, where it drops by one
        end else if (push && count_q != flag_pkg::FIFO_FULL && !(fifo_pop && count_q != 10'h0)) begin
            count_q <= count_q + 10'h1;
        end else if (fifo_pop && count_q != 10'h0 && !(push && count_q != flag_pkg::FIFO_FULL)) begin
            count_q <= count_q - 10'h1;
        end
    end

    // A full keep-oldest queue refuses samples until the host pops one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prim_q.overflow <= 1'b0;
            store_ok_q      <= 1'b1;
        end else if (fifo_pol_q != flag_pkg::POL_OLDEST) begin
            prim_q.overflow <= 1'b0; // R2
            store_ok_q      <= 1'b1;
        end else if (sample_valid && count_q == flag_pkg::FIFO_FULL && !fifo_pop) begin
            prim_q.overflow <= 1'b1; // R1
            store_ok_q      <= 1'b0; // R1
        end else if (fifo_pop) begin
            prim_q.overflow <= 1'b0;
            store_ok_q      <= 1'b1; // R1
        end
    end

    // Level flag rises on the push that takes occupancy past the threshold
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prim_q.queue_level_flag <= 1'b0;
        end else if (push && count_q + 10'h1 > fifo_lvl_q) begin
            prim_q.queue_level_flag <= 1'b1; // R3
        end else if (count_q <= fifo_lvl_q) begin
            prim_q.queue_level_flag <= 1'b0;
        end
    end

    // Registered so it follows occupancy one edge later
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prim_q.nonempty <= 1'b0;
        end else begin
            prim_q.nonempty <= count_q != 10'h0; // R4
        end
    end

    // New-sample flag is frozen low during a data read; arrivals are held back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prim_q.new_sample <= 1'b0;
            pend_q            <= 1'b0;
        end else if (data_read_active) begin
            prim_q.new_sample <= 1'b0; // R5 R6 R8
            pend_q            <= pend_q || sample_valid; // R7
        end else if (pend_q || sample_valid) begin
            prim_q.new_sample <= 1'b1; // R5 R7
            pend_q            <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Knock qualifier, timed in samples
    // ------------------------------------------------------------
    // Strict compare: equal to threshold is not above
    assign above     = sample_magnitude > knock_thr_q;
    // Events fire on the first sample back below threshold
    assign single_ev = kn_q == flag_pkg::KN_ABOVE1 && sample_valid && !above;
    assign double_ev = kn_q == flag_pkg::KN_ABOVE2 && sample_valid && !above;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            kn_q     <= flag_pkg::KN_IDLE;
            kn_cnt_q <= 8'h0;
        // One counter, restarted on each change into a timed state
        end else if (sample_valid) begin
            case (kn_q)
                flag_pkg::KN_IDLE: begin
                    if (above) begin
                        kn_q     <= flag_pkg::KN_ABOVE1;
                        kn_cnt_q <= 8'h1;
                    end
                end
                flag_pkg::KN_ABOVE1, flag_pkg::KN_ABOVE2: begin
                    if (above && kn_cnt_q + 8'h1 >= knock_dur_q) begin
                        kn_q <= flag_pkg::KN_IDLE; // R14 excursion too long
                    end else if (above) begin
                        kn_cnt_q <= kn_cnt_q + 8'h1;
                    end else begin
                        kn_q     <= (kn_q == flag_pkg::KN_ABOVE1) ? flag_pkg::KN_GAP : flag_pkg::KN_IDLE;
                        kn_cnt_q <= 8'h0;
                    end
                end
                flag_pkg::KN_GAP: begin
                    // Excursions inside the gap are ignored
                    if (kn_cnt_q + 8'h1 >= knock_gap_q) begin
                        kn_q     <= flag_pkg::KN_WAIT2; // R15
                        kn_cnt_q <= 8'h0;
                    end else begin
                        kn_cnt_q <= kn_cnt_q + 8'h1;
                    end
                end
                flag_pkg::KN_WAIT2: begin
                    if (above) begin
                        kn_q     <= flag_pkg::KN_ABOVE2; // R15
                        kn_cnt_q <= 8'h1;
                    end else if (kn_cnt_q + 8'h1 >= knock_spn_q) begin
                        kn_q <= flag_pkg::KN_IDLE; // R15 span expired
                    end else begin
                        kn_cnt_q <= kn_cnt_q + 8'h1;
                    end
                end
                default: kn_q <= flag_pkg::KN_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Secondary event flags
    // ------------------------------------------------------------
    // temp_only drops the external channel entirely
    assign over_ev  = temp_over || (!temp_only_q && ext_over); // R12
    assign under_ev = temp_under || (!temp_only_q && ext_under); // R13

    // Sticky flags cleared by reading, fuse error follows its input live; a same-cycle event keeps its flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sec_q <= flag_pkg::SECONDARY_RST; // R16
        end else begin
            sec_q.fuse_error                  <= fuse_uncorrectable; // R9
            sec_q.reserved                    <= 1'b0;
            sec_q.mem_reload                  <= mem_reload_event || (sec_q.mem_reload && !sec_read); // R10 R17
            sec_q.keepalive                   <= keepalive_expired || (sec_q.keepalive && !sec_read); // R11 R17
            sec_q.conversion_over_limit_flag  <= over_ev || (sec_q.conversion_over_limit_flag && !sec_read);
            sec_q.conversion_under_limit_flag <= under_ev || (sec_q.conversion_under_limit_flag && !sec_read);
            sec_q.double_knock                <= double_ev || (sec_q.double_knock && !sec_read); // R15
            sec_q.single_knock                <= single_ev || (sec_q.single_knock && !sec_read); // R14
        end
    end

    // Timer restart rides on the clearing read
    assign keepalive_restart = sec_read; // R11

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Knock bit is shared by single and double
    assign int_ev = {single_ev || double_ev, under_ev, over_ev, keepalive_expired, mem_reload_event,
                     sample_valid && fifo_pol_q == flag_pkg::POL_OLDEST && count_q == flag_pkg::FIFO_FULL,
                     push && count_q + 10'h1 > fifo_lvl_q, sample_valid};

    // Read of the status register clears it, set wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_stat_q <= 8'h0;
        end else if (rd_done && idx == flag_pkg::IDX_INT_STAT) begin
            int_stat_q <= int_ev;
        end else begin
            int_stat_q <= int_stat_q | int_ev;
        end
    end

    // Sticky status makes a plain level output safe
    assign irq = |(int_stat_q & int_mask_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Quiet while reset is held
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    overflow_policy_a: assert property (fifo_pol_q != flag_pkg::POL_OLDEST |=> !prim_q.overflow) // R2
        else $error("overflow flag outside keep-oldest");
    overflow_block_a: assert property (prim_q.overflow && !fifo_pop |-> !fifo_store) // R1
        else $error("sample stored after overflow");
    level_set_a: assert property (push && count_q + 10'h1 > fifo_lvl_q |=> prim_q.queue_level_flag) // R3
        else $error("level flag missed");
    nonempty_a: assert property ($past(count_q) != 10'h0 |-> prim_q.nonempty) // R4
        else $error("nonempty flag wrong");
    read_hold_a: assert property (data_read_active |=> !prim_q.new_sample) // R6
        else $error("new-sample set during data read");
    read_release_a: assert property (data_read_active && sample_valid ##1 !data_read_active
                                     |=> prim_q.new_sample) // R7
        else $error("held sample not flagged after read");
    sample_set_a: assert property (!data_read_active && sample_valid |=> prim_q.new_sample) // R5
        else $error("new-sample not set");
    reload_wins_a: assert property (sec_read && mem_reload_event |=> sec_q.mem_reload) // R17
        else $error("reload lost on read");
    keep_clear_a: assert property (sec_read && !keepalive_expired |=> !sec_q.keepalive && $past(keepalive_restart)) // R11
        else $error("keep-alive not cleared by read");
    temp_only_a: assert property (temp_only_q && ext_over && !temp_over && !sec_q.conversion_over_limit_flag
                                  && !sec_read |=> !sec_q.conversion_over_limit_flag) // R12
        else $error("external over-limit leaked");
    knock_one_a: assert property (single_ev |=> sec_q.single_knock ##0 kn_q == flag_pkg::KN_GAP) // R14
        else $error("single knock missed");
    fuse_a: assert property (fuse_uncorrectable |=> sec_q.fuse_error) // R9
        else $error("fuse error not reported");

    double_knock_c: cover property (double_ev);
    overflow_c:     cover property (prim_q.overflow ##1 fifo_pop);
    read_defer_c:   cover property (data_read_active && sample_valid ##1 !data_read_active);
    irq_c:          cover property (irq && rd_done && idx == flag_pkg::IDX_INT_STAT);
endmodule : sensor_status_flag_logic

// ==== tb/host_model.sv ====
// Host model: APB master issuing one register transfer at a time
`timescale 1ns/1ns
module host_model (
    input  wire logic        ref_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err;
    // Bus idles with no request pending
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end
    // Setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~wd; // Released data no longer shows the old value
    endtask : xfer
endmodule : host_model

// ==== tb/sensor_status_flag_logic_tb.sv ====
// Self-checking bench for the sensor status flag logic
`timescale 1ns/1ns
module sensor_status_flag_logic_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, fifo_store, keepalive_restart, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  ev = 8'h00;
    logic [13:0] mag = 14'h0000;
    logic        fuse = 1'b0;
    integer      seed = 32'h89B62F2F;
    int          num_errors = 0, checks = 0, cnt = 0, ovf = 0, ns = 0, pol = 0;
    int          stores = 0, exp_st = 0, restarts = 0;
    always #50 ref_clk = ~ref_clk;
    // Count stores and timer restarts as the design reports them
    always @(posedge ref_clk) begin
        stores   <= stores + int'(ev[0] && fifo_store === 1'b1);
        restarts <= restarts + int'(keepalive_restart === 1'b1);
    end
    sensor_status_flag_logic i_sensor_status_flag_logic (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(ev[0]), .sample_magnitude(mag), .fifo_pop(ev[1]),
        .fifo_store(fifo_store), .fuse_uncorrectable(fuse), .mem_reload_event(ev[2]),
        .keepalive_expired(ev[3]), .keepalive_restart(keepalive_restart), .temp_over(ev[4]),
        .temp_under(ev[5]), .ext_over(ev[6]), .ext_under(ev[7]), .irq(irq));
    host_model i_host_model (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Idle gap first so pending flag updates land before the setup edge
    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        repeat (2) @(posedge ref_clk);
        i_host_model.xfer(1'b0, idx, 32'h0, rd);
        chk(what, exp, rd);
    endtask : rdc
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        i_host_model.xfer(1'b1, idx, wd, rd);
    endtask : wr
    // One-cycle event pulses; the queue model follows alongside
    task automatic pulse(input logic [7:0] e, input logic [13:0] m);
        @(posedge ref_clk);
        ev  <= e;
        mag <= m;
        @(posedge ref_clk);
        ev  <= 8'h00;
        if (e[0] && pol != 0) begin
            if (pol == 1 && cnt == 512) ovf = 1;
            else if (ovf == 0) begin
                exp_st++;
                if (cnt < 512) cnt++;
            end
        end
        if (e[0]) ns = 1;
        if (e[1] && cnt > 0) begin
            cnt--;
            ovf = 0;
        end
    endtask : pulse
    function automatic logic [31:0] prim();
        return 32'({ovf[0], cnt > 2, cnt != 0, ns[0]});
    endfunction : prim
    task automatic end_sim();
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Watchdog at 10000 cycles, well beyond the expected run of about 1200 cycles
    initial begin
        #1000000;
        num_errors++;
        end_sim();
    end
    initial begin
        logic [8:0] ks;
        ks = 9'b100000010;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'h0);
        rdc("primary", flag_pkg::IDX_PRIMARY, 32'h0);
        chk("irq", 32'h0, irq);
        rdc("unmapped", 8'hFF, 32'h0);
        chk("pslverr", 32'h1, i_host_model.err);
        chk("pready", 32'h1, pready);
        // Keep-oldest queue, level threshold two, filled past full
        wr(flag_pkg::IDX_FIFO_LVL, 32'h2);
        wr(flag_pkg::IDX_FIFO_POL, 32'h1);
        pol = 1;
        for (int i = 1; i <= 513; i++) begin
            pulse(8'h01, 14'($random(seed)) & 14'h03FF);
            if (i == 2 || i == 3 || i == 513) rdc("primary", flag_pkg::IDX_PRIMARY, prim());
        end
        pulse(8'h01, 14'h0000);
        #1 chk("stores", exp_st, stores);
        pulse(8'h02, 14'h0000);
        rdc("primary", flag_pkg::IDX_PRIMARY, prim());
        pulse(8'h01, 14'h0000);
        wr(flag_pkg::IDX_FIFO_POL, 32'h2);
        pol = 2;
        repeat (2) pulse(8'h01, 14'h0000);
        rdc("primary", flag_pkg::IDX_PRIMARY, prim());
        chk("stores", exp_st, stores);
        wr(flag_pkg::IDX_FIFO_POL, 32'h0);
        pol = 0;
        cnt = 0;
        // Data reads clear the new-sample flag; arrivals mid-read land after it
        i_host_model.xfer(1'b0, flag_pkg::IDX_DATA_A_LO, 32'h0, rd);
        ns = 0;
        rdc("primary", flag_pkg::IDX_PRIMARY, prim());
        fork
            i_host_model.xfer(1'b0, flag_pkg::IDX_DATA_B_HI, 32'h0, rd);
            pulse(8'h01, 14'h0000);
        join
        rdc("primary", flag_pkg::IDX_PRIMARY, prim());
        // Secondary events, clear on read, fuse stays live
        fuse <= 1'b1;
        pulse(8'h9C, 14'h0000);
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'hDC);
        #1 chk("restarts", 32'h2, restarts);
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'h80);
        wr(flag_pkg::IDX_CONV_CTL, 32'h1);
        pulse(8'h60, 14'h0000);
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'h84);
        fork
            i_host_model.xfer(1'b0, flag_pkg::IDX_SECONDARY, 32'h0, rd);
            begin
                @(posedge ref_clk);
                pulse(8'h04, 14'h0000);
            end
        join
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'hC0);
        // Short excursion, a gap, then a second within the span
        for (int i = 8; i >= 0; i--) pulse(8'h01, ks[i] ? 14'h0800 : 14'h0010);
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'h83);
        // Excursion as long as the maximum duration is no knock
        for (int i = 0; i < 5; i++) pulse(8'h01, (i < 4) ? 14'h0800 : 14'h0010);
        rdc("secondary", flag_pkg::IDX_SECONDARY, 32'h80);
        // Masked event stays quiet, unmasked one raises the line
        wr(flag_pkg::IDX_INT_MASK, 32'h1 << flag_pkg::INT_RELOAD);
        i_host_model.xfer(1'b0, flag_pkg::IDX_INT_STAT, 32'h0, rd);
        pulse(8'h08, 14'h0000);
        #1 chk("irq", 32'h0, irq);
        pulse(8'h04, 14'h0000);
        #1 chk("irq", 32'h1, irq);
        rdc("int status", flag_pkg::IDX_INT_STAT, 32'h18);
        #1 chk("irq", 32'h0, irq);
        end_sim();
    end
endmodule : sensor_status_flag_logic_tb
